/* src/ttsc_top.v */
// trigger, dma request and slave-mode control of a motor-control timer
// assumes all inputs synchronous to sys_clk_i; counter core outside
//
// Operation
// - adc triggers only when global adc trigger enable is set
// - update event with update trigger enable gives an adc trigger
// - each compare sub-channel match triggers adc when its enable is set
// - dma source select 0 uses compare match, 1 uses update event
// - channels 1-3 request dma on capture or compare; channel 4 compare only
// - A group, channel 4 and update on line one; B group and update on two
// - slave mode select decodes eight counter behaviours
// - mode 0 counts on internal clock whenever enable is set
// - mode 1 trigger reinitialises counter and prescaler
// - trigger reset with update source 0 makes update, flag, reload
// - trigger source select picks etr, cascade, channel1_a raw, channel1_a, channel1_b
// - external trigger is filtered and optionally inverted
// - mode 2 software trigger starts counter while enable is set and self-clears
// - mode 2 hardware trigger edge starts counter while enable is set
// - triggers in modes 1, 2, 3 and 7 set trigger flag; irq if enabled; software clears
// - mode 3 counts once per trigger edge while enable is set
// - modes 4-6 count up or down from channel one transitions
// - mode 7 counts only while trigger valid and enable set
// - cascade select picks basic timers 1-3 or general timers 1-4
// - master output select drives one of eight internal signals
// - quadrature 1 counts channel1_a, 2 counts channel1_b, 3 counts both edges
`timescale 1ns/100ps
`default_nettype none
`include "ttsc_map.vh"

module ttsc_top (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        reset_i,
  // control bits
  input  wire        adc_trigger_global_enable_i,
  input  wire        update_adc_trigger_enable_i,
  input  wire [6:0]  compare_adc_trigger_enable_i,
  input  wire        dma_source_select_i,
  input  wire [2:0]  slave_mode_select_i,
  input  wire [2:0]  trigger_source_i,
  input  wire [2:0]  master_output_select_i,
  input  wire [2:0]  cascade_source_select_i,
  input  wire        update_request_source_i,
  input  wire        count_enable_i,
  input  wire        software_trigger_set_i,
  input  wire        software_update_i,
  input  wire        trigger_irq_enable_i,
  input  wire        trigger_flag_clear_i,
  input  wire [2:0]  ext_trigger_filter_i,
  input  wire        ext_trigger_polarity_i,
  // timer core events (1a,1b,2a,2b,3a,3b,4)
  input  wire [6:0]  compare_match_i,
  input  wire [5:0]  capture_i,
  input  wire        update_event_i,
  input  wire        compare_select_output_i,
  input  wire        ref_out_ch1_a_i,
  input  wire        ref_out_ch2_a_i,
  input  wire        ref_out_ch3_a_i,
  input  wire        ref_out_ch1_b_i,
  input  wire        count_clock_tick_i,
  // trigger inputs
  input  wire        external_trigger_input_i,
  input  wire        channel1_a_i,
  input  wire        chan_a_conditioned_i,
  input  wire        chan_b_conditioned_i,
  input  wire [2:0]  basic_timer_overflow_i,
  input  wire [3:0]  general_timer_overflow_i,
  // outputs toward adc, dma, timers
  output wire        adc_trigger_o,
  output wire        dma_req_a_o,
  output wire        dma_req_b_o,
  output wire        master_out_o,
  // outputs toward counter core and software
  output wire        count_step_o,
  output wire        count_down_o,
  output wire        counter_reinit_o,
  output wire        trigger_update_o,
  output wire        counter_running_o,
  output wire        software_trigger_o,
  output wire        trigger_flag_o,
  output wire        trigger_irq_o
);

  reg        adc_trigger_reg;
  reg        dma_req_a_reg;
  reg        dma_req_b_reg;
  reg        master_out_reg;
  reg        count_step_reg;
  reg        count_down_reg;
  reg        counter_reinit_reg;
  reg        trigger_update_reg;
  reg        running_reg;
  reg        sw_trig_reg;
  reg        trigger_flag_reg;
  reg        trigger_irq_reg;
  reg        etr_sync1_reg;
  reg        etr_sync2_reg;
  reg        etr_filt_reg;
  reg [`TTSC_FLT_CNT_W-1:0] etr_cnt_reg;
  reg        ts_sync1_reg;
  reg        ts_sync2_reg;
  reg        ts_prev_reg;
  reg        qa_prev_reg;
  reg        qb_prev_reg;
  reg        ts_raw;
  reg        itr_sel;
  reg        master_next;
  wire       ext_trigger_conditioned;
  wire       ts_pulse;
  wire       ts_level;
  wire [6:0] dma_src;
  wire       qa_edge;
  wire       qb_edge;
  wire       qa_dir;
  wire       qb_dir;
  wire       quad_step;
  wire       quad_down;
  wire       sms_trig;
  wire       start_evt;
  wire       reset_evt;
  wire       ext_step;
  wire       any_trig;
  wire [`TTSC_FLT_CNT_W-1:0] flt_len;

  // filter length: 0 passes through, else 2^(n[1:0])+1 agreeing samples
  function [`TTSC_FLT_CNT_W-1:0] flt_steps;
    input [`TTSC_FLT_W-1:0] sel;
    begin
      if (sel == 3'h0)
        flt_steps = 4'h0;
      else
        flt_steps = 4'h1 << sel[1:0];
    end
  endfunction

  always @* begin
    case (cascade_source_select_i)
      3'h0:    itr_sel = basic_timer_overflow_i[0];
      3'h1:    itr_sel = basic_timer_overflow_i[1];
      3'h2:    itr_sel = basic_timer_overflow_i[2];
      3'h3:    itr_sel = general_timer_overflow_i[0];
      3'h4:    itr_sel = general_timer_overflow_i[1];
      3'h5:    itr_sel = general_timer_overflow_i[2];
      3'h6:    itr_sel = general_timer_overflow_i[3];
      default: itr_sel = 1'b0;
    endcase
  end

  assign flt_len = flt_steps(ext_trigger_filter_i);
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      etr_sync1_reg <= 1'b0;
      etr_sync2_reg <= 1'b0;
      etr_filt_reg  <= 1'b0;
      etr_cnt_reg   <= 4'h0;
    end else begin
      etr_sync1_reg <= external_trigger_input_i;
      etr_sync2_reg <= etr_sync1_reg;
      if (etr_sync2_reg == etr_filt_reg)
        etr_cnt_reg <= 4'h0;
      else if (etr_cnt_reg >= flt_len) begin
        etr_filt_reg <= etr_sync2_reg;
        etr_cnt_reg  <= 4'h0;
      end else
        etr_cnt_reg <= etr_cnt_reg + 4'h1;
    end
  end
  assign ext_trigger_conditioned = etr_filt_reg ^ ext_trigger_polarity_i;

  always @* begin
    case (trigger_source_i)
      `TTSC_TS_ETR:       ts_raw = ext_trigger_conditioned;
      `TTSC_TS_ITR:       ts_raw = itr_sel;
      `TTSC_TS_CHANNEL1_A_RAW:  ts_raw = channel1_a_i;
      `TTSC_TS_CHANNEL1_A_COND: ts_raw = chan_a_conditioned_i;
      `TTSC_TS_CHANNEL1_B_COND: ts_raw = chan_b_conditioned_i;
      default:            ts_raw = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ts_sync1_reg <= 1'b0;
      ts_sync2_reg <= 1'b0;
      ts_prev_reg  <= 1'b0;
      qa_prev_reg  <= 1'b0;
      qb_prev_reg  <= 1'b0;
    end else begin
      ts_sync1_reg <= ts_raw;
      ts_sync2_reg <= ts_sync1_reg;
      ts_prev_reg  <= ts_sync2_reg;
      qa_prev_reg  <= chan_a_conditioned_i;
      qb_prev_reg  <= chan_b_conditioned_i;
    end
  end
  assign ts_level = ts_sync2_reg;
  assign ts_pulse = ts_sync2_reg & ~ts_prev_reg;

  // direction from edge and other input level
  assign qa_edge = chan_a_conditioned_i ^ qa_prev_reg;
  assign qb_edge = chan_b_conditioned_i ^ qb_prev_reg;
  assign qa_dir  = ~(chan_a_conditioned_i ^ chan_b_conditioned_i);
  assign qb_dir  = chan_a_conditioned_i ^ chan_b_conditioned_i;
  assign quad_step =
    (slave_mode_select_i == `TTSC_SMS_QUAD1) ? qa_edge :
    (slave_mode_select_i == `TTSC_SMS_QUAD2) ? qb_edge :
    (slave_mode_select_i == `TTSC_SMS_QUAD3) ? (qa_edge | qb_edge) : 1'b0;
  assign quad_down = qa_edge ? qa_dir : qb_dir;

  assign sms_trig  = slave_mode_select_i == `TTSC_SMS_TRIG;
  assign start_evt = sms_trig & (sw_trig_reg | ts_pulse);
  assign reset_evt = (slave_mode_select_i == `TTSC_SMS_RESET) & ts_pulse;
  assign ext_step  = (slave_mode_select_i == `TTSC_SMS_EXTCLK) &
                     ts_pulse & count_enable_i;
  assign any_trig  = start_evt | reset_evt |
                     ((slave_mode_select_i == `TTSC_SMS_EXTCLK) & ts_pulse) |
                     ((slave_mode_select_i == `TTSC_SMS_GATED) & ts_pulse);

  // capture or compare on 1-3, compare only on 4
  assign dma_src = dma_source_select_i ? 7'h00 :
                   (compare_match_i | {1'b0, capture_i});

  always @* begin
    case (master_output_select_i)
      `TTSC_MMS_UG:    master_next = software_update_i;
      `TTSC_MMS_EN:    master_next = running_reg;
      `TTSC_MMS_UEV:   master_next = update_event_i;
      `TTSC_MMS_COMPARE_SELECT_OUTPUT: master_next = compare_select_output_i;
      `TTSC_MMS_REF1A: master_next = ref_out_ch1_a_i;
      `TTSC_MMS_REF2A: master_next = ref_out_ch2_a_i;
      `TTSC_MMS_REF3A: master_next = ref_out_ch3_a_i;
      `TTSC_MMS_REF1B: master_next = ref_out_ch1_b_i;
      default:         master_next = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      adc_trigger_reg    <= 1'b0;
      dma_req_a_reg      <= 1'b0;
      dma_req_b_reg      <= 1'b0;
      master_out_reg     <= 1'b0;
      count_step_reg     <= 1'b0;
      count_down_reg     <= 1'b0;
      counter_reinit_reg <= 1'b0;
      trigger_update_reg <= 1'b0;
      running_reg        <= 1'b0;
      sw_trig_reg        <= 1'b0;
      trigger_flag_reg   <= 1'b0;
      trigger_irq_reg    <= 1'b0;
    end else begin
      adc_trigger_reg <= adc_trigger_global_enable_i &
        ((update_adc_trigger_enable_i & update_event_i) |
         (|(compare_adc_trigger_enable_i & compare_match_i)));
      dma_req_a_reg <= dma_src[0] | dma_src[2] | dma_src[4] | dma_src[6] |
                       (dma_source_select_i & update_event_i);
      dma_req_b_reg <= dma_src[1] | dma_src[3] | dma_src[5] |
                       (dma_source_select_i & update_event_i);
      master_out_reg <= master_next;
      if (software_trigger_set_i)
        sw_trig_reg <= 1'b1;
      else if (sms_trig)
        sw_trig_reg <= 1'b0;
      // enable gates running in every mode, trigger mode included
      if (!count_enable_i)
        running_reg <= 1'b0;
      else if (sms_trig)
        running_reg <= running_reg | start_evt;
      else
        running_reg <= 1'b1;
      counter_reinit_reg <= reset_evt;
      trigger_update_reg <= reset_evt & ~update_request_source_i;
      if (any_trig)
        trigger_flag_reg <= 1'b1;
      else if (trigger_flag_clear_i)
        trigger_flag_reg <= 1'b0;
      trigger_irq_reg <= trigger_irq_enable_i &
                         (any_trig | (trigger_flag_reg &
                                      ~trigger_flag_clear_i));
      count_down_reg <= quad_step & quad_down;
      case (slave_mode_select_i)
        `TTSC_SMS_INTCLK: count_step_reg <= count_enable_i &
                                            count_clock_tick_i;
        `TTSC_SMS_RESET:  count_step_reg <= count_enable_i &
                                            count_clock_tick_i & ~reset_evt;
        `TTSC_SMS_TRIG:   count_step_reg <= running_reg & count_clock_tick_i;
        `TTSC_SMS_EXTCLK: count_step_reg <= ext_step;
        `TTSC_SMS_GATED:  count_step_reg <= ts_level & count_enable_i &
                                            count_clock_tick_i;
        default:          count_step_reg <= quad_step;
      endcase
    end
  end

  assign adc_trigger_o      = adc_trigger_reg;
  assign dma_req_a_o        = dma_req_a_reg;
  assign dma_req_b_o        = dma_req_b_reg;
  assign master_out_o       = master_out_reg;
  assign count_step_o       = count_step_reg;
  assign count_down_o       = count_down_reg;
  assign counter_reinit_o   = counter_reinit_reg;
  assign trigger_update_o   = trigger_update_reg;
  assign counter_running_o  = running_reg;
  assign software_trigger_o = sw_trig_reg;
  assign trigger_flag_o     = trigger_flag_reg;
  assign trigger_irq_o      = trigger_irq_reg;

endmodule
`default_nettype wire

/* src/ttsc_map.vh */
// constants for the trigger and slave-mode control block
// included by src/ttsc_top.v; definitions only
`ifndef TTSC_MAP_VH
`define TTSC_MAP_VH
// slave mode select codes
`define TTSC_SMS_INTCLK   3'h0
`define TTSC_SMS_RESET    3'h1
`define TTSC_SMS_TRIG     3'h2
`define TTSC_SMS_EXTCLK   3'h3
`define TTSC_SMS_QUAD1    3'h4
`define TTSC_SMS_QUAD2    3'h5
`define TTSC_SMS_QUAD3    3'h6
`define TTSC_SMS_GATED    3'h7
// trigger source select codes
`define TTSC_TS_ETR       3'h0
`define TTSC_TS_ITR       3'h1
`define TTSC_TS_CHANNEL1_A_RAW  3'h5
`define TTSC_TS_CHANNEL1_A_COND 3'h6
`define TTSC_TS_CHANNEL1_B_COND 3'h7
// master output select codes
`define TTSC_MMS_UG       3'h0
`define TTSC_MMS_EN       3'h1
`define TTSC_MMS_UEV      3'h2
`define TTSC_MMS_COMPARE_SELECT_OUTPUT    3'h3
`define TTSC_MMS_REF1A    3'h4
`define TTSC_MMS_REF2A    3'h5
`define TTSC_MMS_REF3A    3'h6
`define TTSC_MMS_REF1B    3'h7
// dma request source numbers
`define TTSC_DMA_SRC_A    6'h11
`define TTSC_DMA_SRC_B    6'h12
// external trigger filter: field width and step counter width
`define TTSC_FLT_W        3
`define TTSC_FLT_CNT_W    4
`endif

/* verif/ttsc_top_monitor.sv */
// concurrent checks on the trigger and slave-mode control block
// bound to ttsc_top; sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "ttsc_map.vh"
module ttsc_top_monitor (
  // clock, reset and control
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       adc_trigger_global_enable_i,
  input wire logic       update_adc_trigger_enable_i,
  input wire logic [6:0] compare_adc_trigger_enable_i,
  input wire logic       dma_source_select_i,
  input wire logic [2:0] slave_mode_select_i,
  input wire logic [2:0] trigger_source_i,
  input wire logic [2:0] master_output_select_i,
  input wire logic       count_enable_i,
  input wire logic       trigger_flag_clear_i,
  // events and trigger inputs
  input wire logic [6:0] compare_match_i,
  input wire logic [5:0] capture_i,
  input wire logic       update_event_i,
  input wire logic       compare_select_output_i,
  input wire logic       channel1_a_i,
  // outputs
  input wire logic       adc_trigger_o,
  input wire logic       dma_req_a_o,
  input wire logic       dma_req_b_o,
  input wire logic       master_out_o,
  input wire logic       count_step_o,
  input wire logic       counter_reinit_o,
  input wire logic       counter_running_o,
  input wire logic       software_trigger_o,
  input wire logic       trigger_flag_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  AST_ADC_GATE: assert property (
    !adc_trigger_global_enable_i |=> !adc_trigger_o)
    else $error("adc trigger while globally disabled");
  AST_ADC_UPD: assert property (
    adc_trigger_global_enable_i && update_adc_trigger_enable_i
    && update_event_i |=> adc_trigger_o)
    else $error("update event gave no adc trigger");
  AST_ADC_CMP: assert property (
    adc_trigger_global_enable_i
    && |(compare_match_i & compare_adc_trigger_enable_i) |=> adc_trigger_o)
    else $error("compare match gave no adc trigger");
  AST_DMA_CMP: assert property (
    !dma_source_select_i && compare_match_i[6] |=> dma_req_a_o)
    else $error("channel four match gave no dma request");
  AST_DMA_UPD: assert property (
    dma_source_select_i && update_event_i |=> dma_req_a_o && dma_req_b_o)
    else $error("update gave no dma request on both lines");
  AST_DMA_CAP: assert property (
    !dma_source_select_i && capture_i[1] |=> dma_req_b_o)
    else $error("capture gave no dma request");
  AST_REINIT: assert property (
    slave_mode_select_i == `TTSC_SMS_RESET
    && trigger_source_i == `TTSC_TS_CHANNEL1_A_RAW && $rose(channel1_a_i)
    |-> ##[2:4] counter_reinit_o)
    else $error("trigger edge gave no counter reinit");
  AST_SW_START: assert property (
    $rose(software_trigger_o) && count_enable_i
    && slave_mode_select_i == `TTSC_SMS_TRIG
    |-> ##[1:2] (counter_running_o && !software_trigger_o))
    else $error("software trigger did not start and clear");
  AST_FLAG_HOLD: assert property (
    trigger_flag_o && !trigger_flag_clear_i |=> trigger_flag_o)
    else $error("trigger flag dropped without clear");
  AST_GATE_OFF: assert property (
    (slave_mode_select_i == `TTSC_SMS_GATED && !count_enable_i)[*3]
    |=> !count_step_o)
    else $error("gated mode counted while disabled");
  AST_MASTER: assert property (
    master_output_select_i == `TTSC_MMS_COMPARE_SELECT_OUTPUT
    |=> master_out_o == $past(compare_select_output_i))
    else $error("master output not following compare select");

  COV_ADC: cover property (adc_trigger_o);
  COV_REINIT: cover property (counter_reinit_o);
  COV_RUN: cover property ($rose(counter_running_o));
endmodule
bind ttsc_top ttsc_top_monitor u_mon (.*);
`default_nettype wire

/* verif/ttsc_far_model.sv */
// far-side stand-in: counts adc conversion starts
// assumes trigger pulses last one sys_clk_i cycle
`timescale 1ns/100ps
`default_nettype none
module ttsc_far_model (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  // trigger from the block
  input  wire logic adc_trigger_i,
  // conversion count
  output var  int   adc_count_o
);
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) adc_count_o <= 0;
    else if (adc_trigger_i) adc_count_o <= adc_count_o + 1;
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for ttsc_top with a far-side adc model
// assumes ttsc_map.vh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "ttsc_map.vh"
module tb_top;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, count_enable_i = 1'b0;
  logic adc_trigger_global_enable_i = 1'b0, dma_source_select_i = 1'b0;
  logic update_adc_trigger_enable_i = 1'b0, update_event_i = 1'b0;
  logic update_request_source_i = 1'b0, software_update_i = 1'b0;
  logic software_trigger_set_i = 1'b0, trigger_irq_enable_i = 1'b0;
  logic trigger_flag_clear_i = 1'b0, ext_trigger_polarity_i = 1'b0;
  logic compare_select_output_i = 1'b0, ref_out_ch1_a_i = 1'b0;
  logic ref_out_ch2_a_i = 1'b0, ref_out_ch3_a_i = 1'b0;
  logic ref_out_ch1_b_i = 1'b0, count_clock_tick_i = 1'b0;
  logic external_trigger_input_i = 1'b0, channel1_a_i = 1'b0;
  logic chan_a_conditioned_i = 1'b0, chan_b_conditioned_i = 1'b0;
  logic [6:0] compare_adc_trigger_enable_i = 7'h00, compare_match_i = 7'h00;
  logic [5:0] capture_i = 6'h00;
  logic [2:0] slave_mode_select_i = 3'h0, trigger_source_i = 3'h0;
  logic [2:0] master_output_select_i = 3'h0, cascade_source_select_i = 3'h0;
  logic [2:0] ext_trigger_filter_i = 3'h0, basic_timer_overflow_i = 3'h0;
  logic [3:0] general_timer_overflow_i = 4'h0;
  wire        adc_trigger_o, dma_req_a_o, dma_req_b_o, master_out_o;
  wire        count_step_o, count_down_o, counter_reinit_o;
  wire        trigger_update_o, counter_running_o, software_trigger_o;
  wire        trigger_flag_o, trigger_irq_o;
  int         adc_count, mismatches = 0, checked = 0, cycles = 0;

  ttsc_top DUT (.*);
  ttsc_far_model far (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .adc_trigger_i(adc_trigger_o), .adc_count_o(adc_count));

  always #12.5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic t_adc();
    update_adc_trigger_enable_i <= 1'b1;
    compare_adc_trigger_enable_i <= 7'h55;
    for (int g = 0; g < 2; g++) begin
      adc_trigger_global_enable_i <= g[0];
      for (int k = 0; k < 8; k++) begin
        @(posedge sys_clk_i);
        if (k < 7) compare_match_i <= 7'h01 << k;
        else update_event_i <= 1'b1;
        @(posedge sys_clk_i);
        compare_match_i <= 7'h00;
        update_event_i <= 1'b0;
        #1;
        chk("adc_trigger", g == 1 && (k == 7 || k % 2 == 0), adc_trigger_o);
      end
    end
    adc_trigger_global_enable_i <= 1'b0;
    tick(1);
    chk("adc_count", 1'b1, adc_count == 5);
    $display("test adc done");
  endtask

  task automatic t_dma();
    int j;
    for (int s = 0; s < 2; s++) begin
      dma_source_select_i <= s[0];
      for (int k = 0; k < 14; k++) begin
        j = k < 7 ? k : k - 7;
        @(posedge sys_clk_i);
        if (k < 7) compare_match_i <= 7'h01 << k;
        else if (k < 13) capture_i <= 6'h01 << j;
        else update_event_i <= 1'b1;
        @(posedge sys_clk_i);
        compare_match_i <= 7'h00;
        capture_i <= 6'h00;
        update_event_i <= 1'b0;
        #1;
        chk("dma_req_a", k == 13 ? s == 1 : s == 0 && j % 2 == 0, dma_req_a_o);
        chk("dma_req_b", k == 13 ? s == 1 : s == 0 && j % 2 == 1, dma_req_b_o);
      end
    end
    $display("test dma done");
  endtask

  task automatic t_reinit();
    int n;
    slave_mode_select_i <= `TTSC_SMS_RESET;
    trigger_source_i <= `TTSC_TS_CHANNEL1_A_RAW;
    trigger_irq_enable_i <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      update_request_source_i <= u[0];
      tick(4);
      channel1_a_i <= 1'b1;
      n = 0;
      do begin
        tick(1);
        n++;
      end while (counter_reinit_o !== 1'b1 && n < 8);
      chk("counter_reinit", 1'b1, counter_reinit_o);
      chk("trigger_update", u == 0, trigger_update_o);
      tick(1);
      chk("reinit_pulse", 1'b0, counter_reinit_o);
      chk("trigger_flag", 1'b1, trigger_flag_o);
      chk("trigger_irq", 1'b1, trigger_irq_o);
      trigger_flag_clear_i <= 1'b1;
      channel1_a_i <= 1'b0;
      @(posedge sys_clk_i);
      trigger_flag_clear_i <= 1'b0;
      tick(2);
      chk("flag_cleared", 1'b0, trigger_flag_o);
    end
    $display("test reinit done");
  endtask

  task automatic t_run();
    count_enable_i <= 1'b1;
    slave_mode_select_i <= `TTSC_SMS_TRIG;
    tick(3);
    software_trigger_set_i <= 1'b1;
    @(posedge sys_clk_i);
    software_trigger_set_i <= 1'b0;
    #1;
    chk("sw_trigger_set", 1'b1, software_trigger_o);
    tick(1);
    chk("running", 1'b1, counter_running_o);
    chk("sw_trigger_clear", 1'b0, software_trigger_o);
    slave_mode_select_i <= `TTSC_SMS_INTCLK;
    count_enable_i <= 1'b0;
    tick(3);
    chk("stopped", 1'b0, counter_running_o);
    count_enable_i <= 1'b1;
    tick(2);
    chk("internal_run", 1'b1, counter_running_o);
    count_enable_i <= 1'b0;
    slave_mode_select_i <= `TTSC_SMS_GATED;
    repeat (4) begin
      @(posedge sys_clk_i);
      count_clock_tick_i <= 1'b1;
      @(posedge sys_clk_i);
      count_clock_tick_i <= 1'b0;
      #1;
      chk("gated_step", 1'b0, count_step_o);
    end
    $display("test run done");
  endtask

  task automatic t_master();
    logic [4:0] v;
    for (int c = 3; c < 8; c++) begin
      v = 5'h10 >> (c - 3);
      master_output_select_i <= 3'(c);
      {compare_select_output_i, ref_out_ch1_a_i, ref_out_ch2_a_i,
       ref_out_ch3_a_i, ref_out_ch1_b_i} <= v;
      tick(2);
      chk("master_out_hi", 1'b1, master_out_o);
      {compare_select_output_i, ref_out_ch1_a_i, ref_out_ch2_a_i,
       ref_out_ch3_a_i, ref_out_ch1_b_i} <= ~v;
      tick(2);
      chk("master_out_lo", 1'b0, master_out_o);
    end
    $display("test master done");
  endtask

  task automatic t_modes();
    int n;
    // polarity picked before any trigger mode uses it
    ext_trigger_polarity_i <= 1'b1;
    external_trigger_input_i <= 1'b1;
    trigger_source_i <= `TTSC_TS_ETR;
    ext_trigger_filter_i <= 3'h0;
    count_enable_i <= 1'b1;
    tick(8);
    slave_mode_select_i <= `TTSC_SMS_EXTCLK;
    tick(2);
    n = 0;
    for (int p = 0; p < 4; p++) begin
      if (p == 3) count_enable_i <= 1'b0;
      external_trigger_input_i <= 1'b0;
      tick(1);
      external_trigger_input_i <= 1'b1;
      repeat (6) begin
        tick(1);
        n += count_step_o;
      end
    end
    chk("ext_steps", 1'b1, n == 3);
    slave_mode_select_i <= `TTSC_SMS_QUAD1;
    chan_b_conditioned_i <= 1'b1;
    tick(2);
    chan_a_conditioned_i <= 1'b1;
    tick(1);
    chk("quad_step_rise", 1'b1, count_step_o);
    chk("quad_down_rise", 1'b1, count_down_o);
    tick(1);
    chk("quad_step_idle", 1'b0, count_step_o);
    chan_a_conditioned_i <= 1'b0;
    tick(1);
    chk("quad_step_fall", 1'b1, count_step_o);
    chk("quad_down_fall", 1'b0, count_down_o);
    chan_b_conditioned_i <= 1'b0;
    tick(1);
    chk("quad_b_ignored", 1'b0, count_step_o);
    trigger_source_i <= `TTSC_TS_ITR;
    cascade_source_select_i <= 3'h4;
    slave_mode_select_i <= `TTSC_SMS_TRIG;
    tick(2);
    count_enable_i <= 1'b1;
    general_timer_overflow_i <= 4'h1;
    tick(1);
    general_timer_overflow_i <= 4'h0;
    tick(5);
    chk("hw_no_start", 1'b0, counter_running_o);
    general_timer_overflow_i <= 4'h2;
    tick(1);
    general_timer_overflow_i <= 4'h0;
    tick(5);
    chk("hw_start", 1'b1, counter_running_o);
    $display("test modes done");
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_adc();
    t_dma();
    t_reinit();
    t_run();
    t_master();
    t_modes();
    print_verdict();
  end
endmodule
`default_nettype wire
